// ==== vop_defines.vh ====
`ifndef VOP_DEFINES_VH
`define VOP_DEFINES_VH

// Register byte offsets
`define VOP_OFF_CTRL       8'h00
`define VOP_OFF_BORDER     8'h04
`define VOP_OFF_PIXEL      8'h08
`define VOP_OFF_STATUS     8'h0C
`define VOP_OFF_WINDOW     8'h10

// Control fields
`define VOP_CTRL_ENABLE    0
`define VOP_CTRL_WIDE16    1
`define VOP_CTRL_STD625    2

// Reset values
`define VOP_CTRL_RST       32'h00000002
`define VOP_BORDER_RST     32'h00808010
`define VOP_WINDOW_RST     32'h01FF0000

// Clock figures in picoseconds
`define VOP_SYS_PERIOD_PS  20000
`define VOP_VCLK_PERIOD_PS 37037

// Line timing in pixel periods (two bytes each)
`define VOP_HTOT_525       10'd858
`define VOP_HTOT_625       10'd864
`define VOP_HBLK_525       10'd138
`define VOP_HBLK_625       10'd144
`define VOP_HS_START       10'd16
`define VOP_HS_WIDTH       10'd64

// Frame timing in lines
`define VOP_VTOT_525       10'd525
`define VOP_VTOT_625       10'd625
`define VOP_F2_525         10'd263
`define VOP_F2_625         10'd313
`define VOP_VBLK_525       10'd20
`define VOP_VBLK_625       10'd24
`define VOP_VS_FIRST       10'd3
`define VOP_VS_END         10'd6

// Blanking levels
`define VOP_BLANK_Y        8'h10
`define VOP_BLANK_C        8'h80

`endif

// ==== vop_fifo.v ====
`timescale 1ns/10ps
module vop_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             i_clk,
   input  wire             i_rst_n,
   // Fill side
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   // Drain side
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data,
   output wire [AW:0]      o_level
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      count_reg;
   wire            push;
   wire            pop;

   assign o_in_ready  = (count_reg != DEPTH[AW:0]);
   assign o_out_valid = (count_reg != {(AW+1){1'b0}});
   assign o_out_data  = mem_reg[rd_ptr_reg];
   assign o_level     = count_reg;
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end

   // Storage needs no reset; it is never read while empty
   always @(posedge i_clk) begin
      if (push)
         mem_reg[wr_ptr_reg] <= i_in_data;
   end

endmodule

// ==== vop_video_port.v ====
// Contract
// R1 - Sixteen-bit mode: luma bus carries one luminance byte per 13.5 MHz sample; with the generated clock samples come at 12.5 MHz.
// R2 - Sixteen-bit mode: chroma bus carries alternating U and V, aligned with luma.
// R3 - Eight-bit mode: luma bus carries chroma and luma bytes interleaved at 27 MHz; the generated clock gives 25 MHz.
// R4 - Eight-bit mode: chroma bus is unused and not driven.
// R5 - Eight-bit mode: start and end of active video codes are inserted.
// R6 - Line reference high during active part of each line, low in blanking.
// R7 - Vertical reference high during the vertical blanking lines of each field.
// R8 - A 13.5 MHz qualifier marks each sample in sixteen-bit mode; with the generated clock it runs at 12.5 MHz.
// R9 - Composite sync follows the selected 525 or 625 line standard.
// R10 - Frame timing is 525 or 625 lines as programmed.
// R11 - Two-level blanking output separates line blanking from field blanking.
// R12 - Direction strap high drives the video clock pin, low accepts it.
// R13 - Sharing input high releases video and timing outputs to high impedance.
// R14 - Active-low reset re-initialises all logic while held low. The FIFO storage mem_reg has no reset and keeps its contents.
// R15 - Lines outside the picture window are filled with the border colour.
// R16 - All sample, qualifier and sync timing derives from the video clock.
`timescale 1ns/10ps
`include "vop_defines.vh"
module vop_video_port #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW    = 3
) (
   // System
   input  wire        I_CLK,
   input  wire        I_RST_N,
   // APB slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg         PREADY,
   output reg  [31:0] PRDATA,
   output reg         PSLVERR,
   // Video clock pin and straps
   input  wire        I_VIDEO_CLOCK_DIRECTION,
   input  wire        I_VIDEO_CLOCK_PIN,
   output reg         O_VIDEO_CLOCK_PIN,
   output reg         O_VIDEO_CLOCK_PIN_OE,
   input  wire        I_MEMORY_SHARE_TRISTATE,
   // Video data
   output reg  [7:0]  O_LUMA_BUS,
   output reg         O_LUMA_BUS_OE,
   output reg  [7:0]  O_CHROMA_BUS,
   output reg         O_CHROMA_BUS_OE,
   // Timing
   output reg         O_SAMPLE_QUALIFIER,
   output reg         O_LINE_ACTIVE_REF,
   output reg         O_FIELD_BLANK_REF,
   output reg         O_TIMING_OE,
   output reg         O_COMPOSITE_SYNC_OUT_N,
   output reg  [1:0]  O_TWO_LEVEL_BLANKING_OUT
);

   localparam VCLK_HALF_RAW = (`VOP_VCLK_PERIOD_PS / 2) / `VOP_SYS_PERIOD_PS;
   localparam VCLK_HALF     = (VCLK_HALF_RAW < 1) ? 1 : VCLK_HALF_RAW;

   function [9:0] pick;
      input       std625;
      input [9:0] a525;
      input [9:0] a625;
      begin
         pick = std625 ? a625 : a525;
      end
   endfunction

   // Timing reference byte: 1 F V H and protection bits
   function [7:0] ref_code;
      input f;
      input v;
      input h;
      begin
         ref_code = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
      end
   endfunction

   // Reset release and pin synchronisers
   reg        rst_s1_reg;
   reg        rst_n;
   reg        dir_s1_reg;
   reg        dir_s2_reg;
   reg        shr_s1_reg;
   reg        shr_s2_reg;
   reg        vck_s1_reg;
   reg        vck_s2_reg;
   reg        vck_s3_reg;

   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg; // R14
      end
   end

   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         dir_s1_reg <= 1'b0;
         dir_s2_reg <= 1'b0;
         shr_s1_reg <= 1'b0;
         shr_s2_reg <= 1'b0;
         vck_s1_reg <= 1'b0;
         vck_s2_reg <= 1'b0;
         vck_s3_reg <= 1'b0;
      end else begin
         dir_s1_reg <= I_VIDEO_CLOCK_DIRECTION;
         dir_s2_reg <= dir_s1_reg;
         shr_s1_reg <= I_MEMORY_SHARE_TRISTATE;
         shr_s2_reg <= shr_s1_reg;
         vck_s1_reg <= I_VIDEO_CLOCK_PIN;
         vck_s2_reg <= vck_s1_reg;
         vck_s3_reg <= vck_s2_reg;
      end
   end

   // Video clock: divided out or taken from the pin
   reg [7:0] div_cnt_reg;
   reg       vck_out_rise;
   wire      vck_in_rise = vck_s2_reg & ~vck_s3_reg;
   wire      byte_tick   = dir_s2_reg ? vck_out_rise : vck_in_rise; // R12

   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg          <= 8'h00;
         vck_out_rise         <= 1'b0;
         O_VIDEO_CLOCK_PIN    <= 1'b0;
         O_VIDEO_CLOCK_PIN_OE <= 1'b0;
      end else begin
         O_VIDEO_CLOCK_PIN_OE <= dir_s2_reg; // R12
         vck_out_rise         <= 1'b0;
         if (!dir_s2_reg) begin
            div_cnt_reg       <= 8'h00;
            O_VIDEO_CLOCK_PIN <= 1'b0;
         end else if (div_cnt_reg == VCLK_HALF[7:0] - 8'h01) begin
            div_cnt_reg       <= 8'h00;
            O_VIDEO_CLOCK_PIN <= ~O_VIDEO_CLOCK_PIN;
            vck_out_rise      <= ~O_VIDEO_CLOCK_PIN;
         end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
         end
      end
   end

   // Registers
   reg  [31:0] ctrl_reg;
   reg  [31:0] border_reg;
   reg  [31:0] window_reg;
   wire        enable = ctrl_reg[`VOP_CTRL_ENABLE];
   wire        wide16 = ctrl_reg[`VOP_CTRL_WIDE16];
   wire        std625 = ctrl_reg[`VOP_CTRL_STD625];

   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [15:0] fifo_out_data;
   wire [FIFO_AW:0] fifo_level;
   reg         fifo_pop;

   wire access    = PSEL & PENABLE;
   wire pix_write = access & PWRITE & (PADDR == `VOP_OFF_PIXEL);
   wire do_write  = access & PREADY & PWRITE;
   wire fifo_push = do_write & (PADDR == `VOP_OFF_PIXEL);
   wire mapped    = (PADDR == `VOP_OFF_CTRL) | (PADDR == `VOP_OFF_BORDER) |
                    (PADDR == `VOP_OFF_PIXEL) | (PADDR == `VOP_OFF_STATUS) |
                    (PADDR == `VOP_OFF_WINDOW);

   reg  [9:0]  h_reg;
   reg  [9:0]  v_reg;
   reg         ph_reg;
   reg  [31:0] rd_data;

   always @* begin
      case (PADDR)
         `VOP_OFF_CTRL:   rd_data = ctrl_reg;
         `VOP_OFF_BORDER: rd_data = border_reg;
         `VOP_OFF_WINDOW: rd_data = window_reg;
         `VOP_OFF_STATUS: rd_data = {{(5 - FIFO_AW){1'b0}}, fifo_level,
                                     ~fifo_in_ready, ~fifo_out_valid, 4'h0, v_reg, h_reg};
         default:         rd_data = 32'h00000000;
      endcase
   end

   // One wait state; a pixel write waits further while the FIFO is full
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         PREADY     <= 1'b0;
         PRDATA     <= 32'h00000000;
         PSLVERR    <= 1'b0;
         ctrl_reg   <= `VOP_CTRL_RST;
         border_reg <= `VOP_BORDER_RST;
         window_reg <= `VOP_WINDOW_RST;
      end else begin
         if (access && !PREADY) begin
            if (!pix_write || !mapped || fifo_in_ready) begin
               PREADY  <= 1'b1;
               PSLVERR <= ~mapped;
               PRDATA  <= PWRITE ? 32'h00000000 : rd_data;
            end
         end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
         end
         if (do_write && PADDR == `VOP_OFF_CTRL)
            ctrl_reg <= {29'h00000000, PWDATA[2:0]};
         if (do_write && PADDR == `VOP_OFF_BORDER)
            border_reg <= {8'h00, PWDATA[23:0]};
         if (do_write && PADDR == `VOP_OFF_WINDOW)
            window_reg <= {6'h00, PWDATA[25:16], 6'h00, PWDATA[9:0]};
      end
   end

   vop_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .i_clk       (I_CLK),
      .i_rst_n     (rst_n),
      .i_in_valid  (fifo_push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (PWDATA[15:0]),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  (fifo_out_data),
      .o_level     (fifo_level)
   );

   // Raster position
   wire [9:0] htot   = pick(std625, `VOP_HTOT_525, `VOP_HTOT_625);
   wire [9:0] hblk   = pick(std625, `VOP_HBLK_525, `VOP_HBLK_625);
   wire [9:0] vtot   = pick(std625, `VOP_VTOT_525, `VOP_VTOT_625); // R10
   wire [9:0] f2     = pick(std625, `VOP_F2_525, `VOP_F2_625);
   wire [9:0] vblk   = pick(std625, `VOP_VBLK_525, `VOP_VBLK_625);
   wire       field  = (v_reg >= f2);
   wire [9:0] fline  = field ? v_reg - f2 : v_reg;
   wire       h_act  = (h_reg >= hblk);
   wire       v_blk  = (fline < vblk);
   wire       v_sync = (fline >= `VOP_VS_FIRST) && (fline < `VOP_VS_END);
   wire       h_sync = (h_reg >= `VOP_HS_START) && (h_reg < `VOP_HS_START + `VOP_HS_WIDTH);
   wire       in_win = (fline >= window_reg[9:0]) && (fline <= window_reg[25:16]);
   wire       eav    = (h_reg == 10'd0) || (h_reg == 10'd1);
   wire       sav    = (h_reg == hblk - 10'd2) || (h_reg == hblk - 10'd1);
   wire [1:0] code_ix = {(h_reg == 10'd1) || (h_reg == hblk - 10'd1), ph_reg};
   wire       picture = h_act && !v_blk;

   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         h_reg  <= 10'd0;
         v_reg  <= 10'd0;
         ph_reg <= 1'b0;
      end else if (byte_tick) begin // R16
         ph_reg <= ~ph_reg;
         if (ph_reg) begin
            if (h_reg >= htot - 10'd1) begin
               h_reg <= 10'd0;
               v_reg <= (v_reg >= vtot - 10'd1) ? 10'd0 : v_reg + 10'd1;
            end else begin
               h_reg <= h_reg + 10'd1;
            end
         end
      end
   end

   // Current pixel: picture data inside the window, border colour elsewhere
   reg  [15:0] pix_reg;
   reg  [15:0] cur_pix;
   wire [7:0]  brd_c = h_reg[0] ? border_reg[23:16] : border_reg[15:8];

   always @* begin
      fifo_pop = 1'b0;
      cur_pix  = {brd_c, border_reg[7:0]}; // R15
      if (byte_tick && !ph_reg && picture && enable && in_win && fifo_out_valid) begin
         fifo_pop = 1'b1;
         cur_pix  = fifo_out_data;
      end
   end

   // Byte selection for both bus modes
   reg [7:0] luma_next;
   reg [7:0] chroma_next;

   always @* begin
      luma_next   = O_LUMA_BUS;
      chroma_next = O_CHROMA_BUS;
      if (wide16) begin
         if (!ph_reg) begin
            luma_next   = picture ? cur_pix[7:0] : `VOP_BLANK_Y; // R1
            chroma_next = picture ? cur_pix[15:8] : `VOP_BLANK_C; // R2
         end
      end else begin
         chroma_next = 8'h00; // R4
         if (eav || sav) begin
            case (code_ix)
               2'd0:    luma_next = 8'hFF; // R5
               2'd3:    luma_next = ref_code(field, v_blk, eav); // R5
               default: luma_next = 8'h00;
            endcase
         end else if (picture) begin
            luma_next = ph_reg ? pix_reg[7:0] : cur_pix[15:8]; // R3
         end else begin
            luma_next = ph_reg ? `VOP_BLANK_Y : `VOP_BLANK_C;
         end
      end
   end

   // Output stage, all updates on the video byte tick
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pix_reg                  <= 16'h0000;
         O_LUMA_BUS               <= 8'h00;
         O_CHROMA_BUS             <= 8'h00;
         O_SAMPLE_QUALIFIER       <= 1'b0;
         O_LINE_ACTIVE_REF        <= 1'b0;
         O_FIELD_BLANK_REF        <= 1'b0;
         O_COMPOSITE_SYNC_OUT_N   <= 1'b1;
         O_TWO_LEVEL_BLANKING_OUT <= 2'b00;
      end else if (byte_tick) begin
         if (!ph_reg)
            pix_reg <= cur_pix;
         O_LUMA_BUS         <= luma_next;
         O_CHROMA_BUS       <= chroma_next;
         O_SAMPLE_QUALIFIER <= ~ph_reg; // R8
         O_LINE_ACTIVE_REF  <= h_act; // R6
         O_FIELD_BLANK_REF  <= v_blk; // R7
         // Broad pulses invert the line sync during field sync lines
         O_COMPOSITE_SYNC_OUT_N <= v_sync ? h_sync : ~h_sync; // R9
         O_TWO_LEVEL_BLANKING_OUT <= v_blk ? 2'b11 : (h_act ? 2'b00 : 2'b01); // R11
      end
   end

   // Output enables follow the sharing pin, not the byte tick
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_LUMA_BUS_OE   <= 1'b0;
         O_CHROMA_BUS_OE <= 1'b0;
         O_TIMING_OE     <= 1'b0;
      end else begin
         O_LUMA_BUS_OE   <= ~shr_s2_reg; // R13
         O_CHROMA_BUS_OE <= ~shr_s2_reg & wide16; // R4
         O_TIMING_OE     <= ~shr_s2_reg; // R13
      end
   end

endmodule

// ==== vop_encoder_model.sv ====
`timescale 1ns/10ps
module vop_encoder_model (
   // Pin control and sampling
   input  wire         i_dev_drives,
   input  wire         i_pin,
   input  wire [7:0]   i_luma,
   // Board clock and byte history
   output logic        o_clk,
   output logic [31:0] o_hist
);
   // Board crystal stops once the device takes the pin over
   initial begin
      o_clk = 1'b0;
      #7;
      forever #80 o_clk = i_dev_drives ? 1'b0 : ~o_clk;
   end

   // Byte latched on the pin edge, before the next one lands
   always @(posedge i_pin) begin
      o_hist <= {o_hist[23:0], i_luma};
   end
endmodule

// ==== vop_video_port_asserts.sv ====
`timescale 1ns/10ps
module vop_video_port_asserts (
   input wire       I_CLK,
   input wire       I_RST_N,
   input wire       PREADY,
   input wire       PSLVERR,
   input wire       I_VIDEO_CLOCK_DIRECTION,
   input wire       O_VIDEO_CLOCK_PIN,
   input wire       O_VIDEO_CLOCK_PIN_OE,
   input wire       I_MEMORY_SHARE_TRISTATE,
   input wire       O_LUMA_BUS_OE,
   input wire       O_CHROMA_BUS_OE,
   input wire       O_TIMING_OE,
   input wire       O_SAMPLE_QUALIFIER,
   input wire       O_LINE_ACTIVE_REF,
   input wire       O_FIELD_BLANK_REF,
   input wire       O_COMPOSITE_SYNC_OUT_N,
   input wire [1:0] O_TWO_LEVEL_BLANKING_OUT
);
   // Internal reset lags the pin by its synchroniser
   logic [2:0] rst_age;
   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_age <= 3'h0;
      end else if (rst_age != 3'h7) begin
         rst_age <= rst_age + 3'h1;
      end
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (rst_age != 3'h7);

   sequence dir_high; I_VIDEO_CLOCK_DIRECTION [*6]; endsequence
   sequence dir_low; !I_VIDEO_CLOCK_DIRECTION [*6]; endsequence
   sequence share_on; I_MEMORY_SHARE_TRISTATE [*6]; endsequence

   chk_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   chk_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   chk_dir_drive: assert property (dir_high |-> O_VIDEO_CLOCK_PIN_OE)
      else $error("clock pin not driven");
   chk_dir_input: assert property (dir_low |-> !O_VIDEO_CLOCK_PIN_OE && !O_VIDEO_CLOCK_PIN)
      else $error("clock pin driven");
   chk_share_release: assert property (share_on |-> !O_LUMA_BUS_OE && !O_CHROMA_BUS_OE
      && !O_TIMING_OE)
      else $error("outputs not released");
   chk_chroma_follow: assert property (O_CHROMA_BUS_OE |-> O_LUMA_BUS_OE)
      else $error("chroma driven alone");
   chk_line_on_pixel: assert property ($changed(O_LINE_ACTIVE_REF)
      |-> $rose(O_SAMPLE_QUALIFIER))
      else $error("line ref off pixel");
   chk_qual_pulse: assert property ($rose(O_SAMPLE_QUALIFIER) |-> ##[1:24] !O_SAMPLE_QUALIFIER)
      else $error("qualifier stuck");
   chk_blank_active: assert property (O_LINE_ACTIVE_REF && !O_FIELD_BLANK_REF
      |-> O_TWO_LEVEL_BLANKING_OUT == 2'b00)
      else $error("blanking in active");
   chk_sync_active: assert property (O_LINE_ACTIVE_REF && !O_FIELD_BLANK_REF
      |-> O_COMPOSITE_SYNC_OUT_N)
      else $error("sync in active");
   chk_blank_field: assert property (O_FIELD_BLANK_REF |-> O_TWO_LEVEL_BLANKING_OUT == 2'b11)
      else $error("field blank level");
endmodule

bind vop_video_port vop_video_port_asserts i_chk (
   .I_CLK, .I_RST_N, .PREADY, .PSLVERR, .I_VIDEO_CLOCK_DIRECTION, .O_VIDEO_CLOCK_PIN,
   .O_VIDEO_CLOCK_PIN_OE, .I_MEMORY_SHARE_TRISTATE, .O_LUMA_BUS_OE, .O_CHROMA_BUS_OE,
   .O_TIMING_OE, .O_SAMPLE_QUALIFIER, .O_LINE_ACTIVE_REF, .O_FIELD_BLANK_REF,
   .O_COMPOSITE_SYNC_OUT_N, .O_TWO_LEVEL_BLANKING_OUT
);

// ==== tb_top.sv ====
`timescale 1ns/10ps
`include "vop_defines.vh"
module tb_top;
   logic        clk, rst_n, psel, penable, pwrite, strap, share, rerr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rdata;
   int          err_count, n_checks, cnt;
   time         t0;
   wire         pready, pslverr, vclk, vclk_oe, enc_clk, luma_oe, chroma_oe;
   wire         qual, lref, fref, tim_oe, composite_sync_out_n;
   wire [1:0]   blank;
   wire [31:0]  prdata, hist;
   wire [7:0]   luma, chroma;
   wire         vpin = vclk_oe ? vclk : enc_clk;

   vop_video_port i_dut (
      .I_CLK(clk), .I_RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .I_VIDEO_CLOCK_DIRECTION(strap), .I_VIDEO_CLOCK_PIN(vpin), .O_VIDEO_CLOCK_PIN(vclk),
      .O_VIDEO_CLOCK_PIN_OE(vclk_oe), .I_MEMORY_SHARE_TRISTATE(share),
      .O_LUMA_BUS(luma), .O_LUMA_BUS_OE(luma_oe), .O_CHROMA_BUS(chroma),
      .O_CHROMA_BUS_OE(chroma_oe), .O_SAMPLE_QUALIFIER(qual), .O_LINE_ACTIVE_REF(lref),
      .O_FIELD_BLANK_REF(fref), .O_TIMING_OE(tim_oe), .O_COMPOSITE_SYNC_OUT_N(composite_sync_out_n),
      .O_TWO_LEVEL_BLANKING_OUT(blank)
   );

   vop_encoder_model i_enc (
      .i_dev_drives(vclk_oe), .i_pin(vpin), .i_luma(luma), .o_clk(enc_clk), .o_hist(hist)
   );

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Bounded only by the watchdog: a full FIFO may stall a write for many lines
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp,
                       input logic e);
      apb(1'b0, a, 32'h0);
      check(name, rdata, exp);
      check("slverr", {31'h0, rerr}, {31'h0, e});
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // About 92k cycles expected, mostly waiting for the first picture line
   initial begin
      #1950000;
      err_count++;
      test_done();
   end

   initial begin
      {rst_n, psel, penable, pwrite, strap, share} = 6'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_count = 0;
      n_checks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("ctrl", 8'h00, 32'h00000002, 1'b0);
      rchk("border", 8'h04, 32'h00808010, 1'b0);
      rchk("window", 8'h10, 32'h01FF0000, 1'b0);
      rchk("pixel", 8'h08, 32'h0, 1'b0);
      rchk("hole", 8'h14, 32'h0, 1'b1);
      $display("test registers done");
      apb(1'b1, 8'h00, 32'h00000001);
      @(posedge lref);
      #1;
      check("sav", hist, 32'hFF0000AB);
      check("chroma idle", {23'h0, chroma_oe, chroma}, 32'h0);
      check("sync blank", {29'h0, composite_sync_out_n, blank}, 32'h7);
      repeat (2) @(posedge vpin);
      #1;
      check("mux bytes", {16'h0, hist[15:0]}, 32'h8010);
      cnt = 2;
      while (lref === 1'b1) begin
         @(posedge vpin);
         cnt++;
      end
      // Fall lands just after the tick that opens blanking
      check("active ticks", cnt, 2 * (`VOP_HTOT_525 - `VOP_HBLK_525) + 1);
      repeat (3) @(posedge vpin);
      #1;
      check("eav", hist, 32'hFF0000B6);
      $display("test eight bit done");
      apb(1'b1, 8'h00, 32'h00000003);
      @(posedge lref);
      repeat (2) @(posedge clk);
      #1;
      check("wide bus", {14'h0, luma_oe, chroma_oe, luma, chroma}, 32'h31080);
      @(posedge qual);
      t0 = $time;
      @(posedge qual);
      check("qual period", 32'($time - t0), 32'd320);
      @(posedge clk);
      share <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check("released", {29'h0, luma_oe, chroma_oe, tim_oe}, 32'h0);
      @(posedge clk);
      share <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check("reclaimed", {29'h0, luma_oe, chroma_oe, tim_oe}, 32'h7);
      $display("test sixteen bit done");
      apb(1'b1, 8'h00, 32'h00000002);
      for (int i = 0; i < 8; i++) apb(1'b1, 8'h08, {16'h0, 8'h40 + 8'(i), 8'h20 + 8'(i)});
      apb(1'b0, 8'h0C, 32'h0);
      check("fifo full", rdata & 32'h3F000000, 32'h22000000);
      @(posedge clk);
      strap <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check("clock drive", {31'h0, vclk_oe}, 32'h1);
      apb(1'b1, 8'h04, 32'h00C0A050);
      apb(1'b1, 8'h00, 32'h00000003);
      apb(1'b1, 8'h08, 32'h00004828);
      do apb(1'b0, 8'h0C, 32'h0); while (rdata[24] !== 1'b1);
      check("fifo empty", rdata & 32'h3F000000, 32'h01000000);
      @(posedge lref);
      repeat (2) @(posedge clk);
      #1;
      check("border", {23'h0, fref, luma}, 32'h50);
      $display("test fifo done");
      // Switch inside line blanking so the line reference keeps its pixel phase
      @(negedge lref);
      apb(1'b1, 8'h00, 32'h00000007);
      @(posedge lref);
      t0 = $time;
      @(posedge lref);
      // Generated clock gives one pixel per 80 ns
      check("line period", 32'($time - t0), 32'(`VOP_HTOT_625) * 32'd80);
      #1;
      check("long blanking", {31'h0, fref}, 32'h1);
      $display("test line standard done");
      test_done();
   end
endmodule
